// ### verilog/bcld_regs.vh
// register offsets, field positions, reset values and timing counts
`ifndef BCLD_REGS_VH
`define BCLD_REGS_VH

// ------------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------------
`define BCLD_CTRL_OFS 12'h000
`define BCLD_LIMIT_OFS 12'h004
`define BCLD_DEMAND_OFS 12'h008
`define BCLD_RDBK_OFS 12'h00C
`define BCLD_STAT_OFS 12'h010
`define BCLD_IRQST_OFS 12'h014
`define BCLD_IRQMSK_OFS 12'h018
`define BCLD_CURR_OFS 12'h01C

// ------------------------------------------------------------------
// control register fields
// ------------------------------------------------------------------
`define BCLD_CTRL_RUN 0
`define BCLD_CTRL_BRAKE 1
`define BCLD_CTRL_CURMODE 2
`define BCLD_CTRL_RBSEL_LO 4
`define BCLD_CTRL_RBSEL_HI 6
`define BCLD_CTRL_RESET 32'h00000000

// ------------------------------------------------------------------
// limit register fields: max threshold select, scale select and gain
// ------------------------------------------------------------------
`define BCLD_LIM_MIT_LO 0
`define BCLD_LIM_MIT_HI 1
`define BCLD_LIM_SCL_LO 4
`define BCLD_LIM_SCL_HI 7
`define BCLD_LIM_GAIN_LO 8
`define BCLD_LIM_GAIN_HI 9
`define BCLD_LIMIT_RESET 32'h000000F3

// ------------------------------------------------------------------
// readback select codes and interrupt bits
// ------------------------------------------------------------------
`define BCLD_RBS_SUPPLY_CUR 3'h2
`define BCLD_RBS_DEMAND 3'h5
`define BCLD_IRQ_OVERCUR 0
`define BCLD_IRQ_PULLDOWN 1

// ------------------------------------------------------------------
// timing
// ------------------------------------------------------------------
`define BCLD_CLK_MHZ 200
`define BCLD_AVG_SHIFT 4

`endif

// ### verilog/bcld_sync.v
// three-stage synchroniser with agreement check for pin inputs
`timescale 1ns/100ps
`default_nettype none

module bcld_sync #(
  parameter RESET_VAL = 1'b1
) (
  input wire clk_sys,
  input wire rstn,
  input wire pinIn,
  output reg pinOut
);

  reg stage1Reg; // first flop, read only by stage2Reg
  reg stage2Reg; // second flop
  reg stage3Reg; // third flop

  // shift chain; level moves only when stages two and three agree
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      stage1Reg <= RESET_VAL;
      stage2Reg <= RESET_VAL;
      stage3Reg <= RESET_VAL;
      pinOut <= RESET_VAL;
    end else begin
      stage1Reg <= pinIn;
      stage2Reg <= stage1Reg;
      stage3Reg <= stage2Reg;
      if (stage2Reg == stage3Reg) begin
        pinOut <= stage3Reg;
      end
    end
  end

endmodule
`default_nettype wire

// ### verilog/bcld_ctrl.v
// brake, current limit, over-current flag and line pull-down control
`timescale 1ns/100ps
`default_nettype none
`include "bcld_regs.vh"

// Functional notes
// - run and brake: all low sides on
// - flag PWM logic when current exceeds limit
// - speed modes: limit is max times scale
// - current mode: limit from demand top five bits
// - report filtered average current count
// - pull-down active while control input low
// - undriven control input reads high
// - fault output may drive pull-down control input
// - readback select two shows supply current
module bcld_ctrl #(
  parameter SENSE_W = 10
) (
  input wire clk_sys,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [SENSE_W-1:0] senseLevel,
  input wire [2:0] pwmPhaseHigh,
  input wire [2:0] pwmPhaseLow,
  input wire line_pulldown_control_in,
  input wire faultCondition,
  output reg [2:0] gateHigh,
  output reg [2:0] gateLow,
  output reg overCurrent,
  output reg linPulldownEn,
  output reg fault_indicator_out,
  output reg irq
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [31:0] ctrlReg; // run, brake, mode, readback select
  reg [31:0] limitReg; // threshold select, scale, gain
  reg [9:0] demandReg; // ten-bit demand input
  reg [1:0] irqStatReg; // sticky events
  reg [1:0] irqMaskReg; // interrupt enables
  reg [SENSE_W+`BCLD_AVG_SHIFT-1:0] avgAccReg; // filter accumulator
  reg [9:0] supplyCurReg; // average current readback count
  reg [SENSE_W-1:0] limitReg2; // computed threshold
  reg overCurPrevReg; // edge detect of flag
  reg pullPrevReg; // edge detect of pull-down

  // decoded fields and bus qualifiers
  wire ltxSync; // synchronised control input
  wire runBit;
  wire brakeBit;
  wire curMode;
  wire [2:0] rbSel;
  wire [1:0] mitSel;
  wire [3:0] sclSel;
  wire apbWrite;
  wire apbRead;
  wire [1:0] events;
  wire [31:0] demandMerged; // demand word after byte-lane merge
  // combinational results
  reg [9:0] readbackVal;
  reg [SENSE_W-1:0] maxThr;
  reg [SENSE_W+3:0] prodScl;
  reg [SENSE_W+4:0] prodDem;
  reg [SENSE_W-1:0] limitNext;
  reg [31:0] rdNext;
  reg decErr;

  // field extraction from the control and limit words
  assign runBit = ctrlReg[`BCLD_CTRL_RUN];
  assign brakeBit = ctrlReg[`BCLD_CTRL_BRAKE];
  assign curMode = ctrlReg[`BCLD_CTRL_CURMODE];
  assign rbSel = ctrlReg[`BCLD_CTRL_RBSEL_HI:`BCLD_CTRL_RBSEL_LO];
  assign mitSel = limitReg[`BCLD_LIM_MIT_HI:`BCLD_LIM_MIT_LO];
  assign sclSel = limitReg[`BCLD_LIM_SCL_HI:`BCLD_LIM_SCL_LO];
  // writes act at the access edge; reads are captured at the setup edge
  assign apbWrite = psel & penable & pwrite;
  assign apbRead = psel & ~penable & ~pwrite;

  // merge byte lanes of a write into an old word
  function [31:0] laneMerge;
    input [31:0] oldVal;
    input [31:0] newVal;
    input [3:0] strb;
    integer i;
    begin
      // lanes without a strobe keep their old byte
      laneMerge = oldVal;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          laneMerge[i*8 +: 8] = newVal[i*8 +: 8];
        end
      end
    end
  endfunction

  // demand write: lanes merged into the zero-extended ten-bit word
  assign demandMerged = laneMerge({22'h000000, demandReg}, pwdata,
                                  pstrb);

  // ----------------------------------------------------------------
  // pin input synchroniser; reset value high as if pulled up
  // ----------------------------------------------------------------
  // the pin is outside the clock domain; a level change is accepted
  // only once the second and third stages agree
  bcld_sync #(
    .RESET_VAL(1'b1)
  ) uSyncLtx (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .pinIn(line_pulldown_control_in),
    .pinOut(ltxSync)
  );

  // ----------------------------------------------------------------
  // threshold computation
  // ----------------------------------------------------------------
  always @* begin
    // codes stand for fixed fractions, chosen freely for this block
    // max threshold as fraction of full scale, by select code
    case (mitSel)
      2'h0: maxThr = {2'b00, {(SENSE_W-2){1'b1}}};
      2'h1: maxThr = {1'b0, 1'b1, {(SENSE_W-2){1'b0}}};
      2'h2: maxThr = {1'b1, {(SENSE_W-1){1'b0}}} - 1'b1;
      default: maxThr = {SENSE_W{1'b1}};
    endcase
    // scale in sixteenths: (code+1)/16
    prodScl = maxThr * ({1'b0, sclSel} + 5'h01);
    // demand top five bits as a ratio of 32
    prodDem = maxThr * demandReg[9:5];
    // both products keep every bit, so the cut below only drops the
    // fractional part of the scale or demand ratio
    if (curMode) begin
      limitNext = prodDem[SENSE_W+4:5];
    end else begin
      limitNext = prodScl[SENSE_W+3:4];
    end
  end

  // ----------------------------------------------------------------
  // readback mux
  // ----------------------------------------------------------------
  // ten-bit word chosen by the readback select field
  always @* begin
    if (rbSel == `BCLD_RBS_SUPPLY_CUR) begin
      readbackVal = supplyCurReg;
    end else if (rbSel == `BCLD_RBS_DEMAND) begin
      readbackVal = demandReg;
    end else begin
      readbackVal = 10'h000;
    end
  end

  // ----------------------------------------------------------------
  // read data decode
  // ----------------------------------------------------------------
  always @* begin
    // defaults give zero data and no error; the last branch flags unmapped addresses
    rdNext = 32'h00000000;
    decErr = 1'b0;
    if (paddr == `BCLD_CTRL_OFS) begin
      rdNext = {25'h0000000, ctrlReg[6:0]};
    end else if (paddr == `BCLD_LIMIT_OFS) begin
      rdNext = {22'h000000, limitReg[9:0]};
    end else if (paddr == `BCLD_DEMAND_OFS) begin
      rdNext = {22'h000000, demandReg};
    end else if (paddr == `BCLD_RDBK_OFS) begin
      rdNext = {22'h000000, readbackVal};
    end else if (paddr == `BCLD_STAT_OFS) begin
      rdNext = {28'h0000000, fault_indicator_out, linPulldownEn,
                overCurrent, ltxSync};
    end else if (paddr == `BCLD_IRQST_OFS) begin
      rdNext = {30'h00000000, irqStatReg};
    end else if (paddr == `BCLD_IRQMSK_OFS) begin
      rdNext = {30'h00000000, irqMaskReg};
    end else if (paddr == `BCLD_CURR_OFS) begin
      rdNext = {22'h000000, supplyCurReg};
    end else begin
      decErr = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // APB slave: one wait-free access phase
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrlReg <= `BCLD_CTRL_RESET;
      limitReg <= `BCLD_LIMIT_RESET;
      demandReg <= 10'h000;
      irqMaskReg <= 2'h0;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      // ready raised during setup so access phase completes at once
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & decErr;
      // read data is captured at the setup edge so that it stands in
      // the access cycle, when the master samples it with pready
      if (apbRead) begin
        prdata <= rdNext;
      end
      // refused writes change nothing; irq status is cleared in its own block, other words are read-only
      if (apbWrite && !decErr) begin
        if (paddr == `BCLD_CTRL_OFS) begin
          ctrlReg <= laneMerge(ctrlReg, pwdata, pstrb);
        end else if (paddr == `BCLD_LIMIT_OFS) begin
          limitReg <= laneMerge(limitReg, pwdata, pstrb);
        end else if (paddr == `BCLD_DEMAND_OFS) begin
          demandReg <= demandMerged[9:0];
        end else if (paddr == `BCLD_IRQMSK_OFS) begin
          irqMaskReg <= pwdata[1:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // sticky interrupt status, set wins over write-one-to-clear
  // ----------------------------------------------------------------
  // rising edges of the flag and the pull-down; the previous values
  // reset low like their sources, so no false edge follows reset
  assign events = {linPulldownEn & ~pullPrevReg,
                   overCurrent & ~overCurPrevReg};

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irqStatReg <= 2'h0;
      overCurPrevReg <= 1'b0;
      pullPrevReg <= 1'b0;
      irq <= 1'b0;
    end else begin
      overCurPrevReg <= overCurrent;
      pullPrevReg <= linPulldownEn;
      if (apbWrite && paddr == `BCLD_IRQST_OFS) begin
        irqStatReg <= (irqStatReg & ~pwdata[1:0]) | events;
      end else begin
        irqStatReg <= irqStatReg | events;
      end
      // level output, one cycle behind the status and mask bits
      irq <= |(irqStatReg & irqMaskReg);
    end
  end

  // ----------------------------------------------------------------
  // current comparator, average filter and gate drive
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      // gates off and fault output inactive while in reset
      limitReg2 <= {SENSE_W{1'b0}};
      avgAccReg <= {(SENSE_W+`BCLD_AVG_SHIFT){1'b0}};
      supplyCurReg <= 10'h000;
      overCurrent <= 1'b0;
      gateHigh <= 3'h0;
      gateLow <= 3'h0;
      linPulldownEn <= 1'b0;
      fault_indicator_out <= 1'b1;
    end else begin
      // threshold registered once to break the multiplier path
      limitReg2 <= limitNext;
      // over-current is a plain level; the pwm logic outside decides
      // what to do with it
      overCurrent <= (senseLevel > limitReg2);
      // first-order filter: acc += x - acc/16
      // steady state holds sixteen times the input, so the top ten
      // bits of the accumulator are the average count
      avgAccReg <= avgAccReg + senseLevel
                   - avgAccReg[SENSE_W+`BCLD_AVG_SHIFT-1:`BCLD_AVG_SHIFT];
      supplyCurReg <= avgAccReg[SENSE_W+`BCLD_AVG_SHIFT-1:
                                `BCLD_AVG_SHIFT+SENSE_W-10];
      // brake overrides pwm requests, but only while run is set
      if (!runBit) begin
        gateHigh <= 3'h0;
        gateLow <= 3'h0;
      end else if (brakeBit) begin
        gateHigh <= 3'h0;
        gateLow <= 3'h7;
      end else begin
        // high side masked where the same phase asks for its low side
        gateHigh <= pwmPhaseHigh & ~pwmPhaseLow;
        gateLow <= pwmPhaseLow;
      end
      // pull-down follows the synchronised pin; a low pin turns it on
      linPulldownEn <= ~ltxSync;
      // active-low fault output; may be wired to the control input
      fault_indicator_out <= ~faultCondition;
    end
  end

endmodule
`default_nettype wire

// ### verif/bcld_ctrl_sva.sv
// assertion checker for the brake and current limit block
`timescale 1ns/100ps
`default_nettype none
module bcld_ctrl_sva #(
  parameter SENSE_W = 10
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [SENSE_W-1:0] senseLevel,
  input wire logic line_pulldown_control_in,
  input wire logic [2:0] gateHigh,
  input wire logic [2:0] gateLow,
  input wire logic overCurrent,
  input wire logic linPulldownEn
);
  logic runQ;  // shadow of the run bit
  logic brkQ;  // shadow of the brake bit
  // track control writes at the edge that completes them
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      runQ <= 1'b0;
      brkQ <= 1'b0;
    end else if (psel && penable && pready && pwrite && pstrb[0]
                 && paddr == 12'h000) begin
      runQ <= pwdata[0];
      brkQ <= pwdata[1];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_done;
    psel && penable && pready;
  endsequence
  a_ready_pulse: assert property (s_setup |=> pready ##1 !pready)
    else $error("pready not one cycle after setup");
  a_unmapped_err: assert property (s_done and (paddr > 12'h01C) |-> pslverr)
    else $error("no error on unmapped address");
  a_err_rdzero: assert property (s_done and (pslverr && !pwrite) |->
    prdata == 32'h00000000) else $error("refused read gave data");
  a_brake_gates: assert property (
    runQ && brkQ && $past(runQ && brkQ) |->
    gateLow == 3'h7 && gateHigh == 3'h0)
    else $error("brake gates wrong");
  a_idle_off: assert property (!runQ && $past(!runQ) |->
    gateLow == 3'h0 && gateHigh == 3'h0)
    else $error("gates on while stopped");
  a_no_overlap: assert property ((gateHigh & gateLow) == 3'h0)
    else $error("high and low side on together");
  a_zero_noover: assert property (senseLevel == 0 [*3] |->
    !overCurrent) else $error("over-current with zero sense");
  a_pin_low_on: assert property (!line_pulldown_control_in [*7] |->
    linPulldownEn) else $error("pull-down off with pin low");
  a_pin_high_off: assert property (line_pulldown_control_in [*7] |->
    !linPulldownEn) else $error("pull-down on with pin high");
endmodule
bind bcld_ctrl bcld_ctrl_sva #(.SENSE_W(SENSE_W)) i_sva (
  .clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .senseLevel(senseLevel), .gateHigh(gateHigh), .gateLow(gateLow),
  .line_pulldown_control_in(line_pulldown_control_in),
  .overCurrent(overCurrent), .linPulldownEn(linPulldownEn));
`default_nettype wire

// ### verif/bcld_bridge_model.sv
// bridge and line partner model for the brake and current limit block
`timescale 1ns/100ps
`default_nettype none
module bcld_bridge_model (
  input wire logic [9:0] shuntLevel,
  input wire logic useDiag,
  input wire logic fault_indicator_out,
  input wire logic linPulldownEn,
  output wire logic [9:0] senseLevel,
  output wire logic ltxPin,
  output wire logic linLine
);
  // sense amplifier follows the shunt current chosen by the bench
  assign senseLevel = shuntLevel;
  // fault output drives the pin directly, else the pull-up holds it high
  assign ltxPin = useDiag ? fault_indicator_out : 1'b1;
  // ecu line: passive pull-up, pulled low only by the pull-down
  assign linLine = linPulldownEn ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// ### verif/tb.sv
// self-checking bench for the brake and current limit block
`timescale 1ns/100ps
`default_nettype none
`include "bcld_regs.vh"
module tb;
  logic clk_sys, rstn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [3:0] pstrb;
  logic [9:0] senseLevel, shunt, v;
  logic [2:0] pwmH, pwmL, gateHigh, gateLow;
  logic ltxPin, faultCond, useDiag, overCurrent, linPulldownEn;
  logic faultOut, irq, linLine;
  logic [15:0] lfsrSt;
  integer miscompares, n_checks, cyc, i;
  bcld_ctrl i_dut (.clk_sys(clk_sys), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .senseLevel(senseLevel), .pwmPhaseHigh(pwmH), .pwmPhaseLow(pwmL),
    .line_pulldown_control_in(ltxPin), .faultCondition(faultCond),
    .gateHigh(gateHigh), .gateLow(gateLow), .overCurrent(overCurrent),
    .linPulldownEn(linPulldownEn), .fault_indicator_out(faultOut),
    .irq(irq));
  bcld_bridge_model i_model (.shuntLevel(shunt), .useDiag(useDiag),
    .fault_indicator_out(faultOut), .linPulldownEn(linPulldownEn),
    .senseLevel(senseLevel), .ltxPin(ltxPin), .linLine(linLine));
  // next state of the stimulus shift register
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // random pwm requests every cycle, and the hang limit
  always @(posedge clk_sys) begin
    lfsrSt <= nxt(lfsrSt);
    pwmH <= lfsrSt[2:0];
    pwmL <= lfsrSt[5:3];
    cyc = cyc + 1;
    if (cyc == 20000) begin
      miscompares = miscompares + 1;
      wrap_up;
    end
  end
  // one apb transfer; waits for pready, keeps data and error
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    begin
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
        @(posedge clk_sys);
      end while (pready !== 1'b1);
      rdv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // compare and count
  task chk(input string nm, input logic [31:0] got, input logic [31:0] e);
    begin
      n_checks = n_checks + 1;
      if (got !== e) begin
        miscompares = miscompares + 1;
        $display("Error %s expected %h seen %h", nm, e, got);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    {miscompares, n_checks, cyc} = 0;
    {rstn, psel, penable, pwrite, faultCond, useDiag} = 6'h00;
    {paddr, pwdata, shunt} = 0;
    pstrb = 4'hF;
    lfsrSt = 16'h9569;
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    // reset values and an unmapped place
    apb(0, `BCLD_LIMIT_OFS, 0);
    chk("limit", rdv, `BCLD_LIMIT_RESET);
    apb(1, 12'h040, 32'hFFFFFFFF);
    chk("wr err", err, 1);
    apb(0, 12'h040, 0);
    chk("rd err", err, 1);
    chk("rd zero", rdv, 0);
    $display("done reset and map");
    // braking, then brake without run
    apb(1, `BCLD_CTRL_OFS, 32'h3);
    repeat (3) @(posedge clk_sys);
    chk("brake", {gateHigh, gateLow}, 6'h07);
    apb(1, `BCLD_CTRL_OFS, 32'h2);
    repeat (3) @(posedge clk_sys);
    chk("idle", {gateHigh, gateLow}, 6'h00);
    $display("done brake");
    // current mode: low demand bits give a zero limit
    apb(1, `BCLD_CTRL_OFS, 32'h4);
    for (i = 0; i < 5; i = i + 1) begin
      v = (i == 4) ? 10'h3FF : {5'h00, lfsrSt[4:0]};
      apb(1, `BCLD_DEMAND_OFS, {22'h0, v});
      shunt <= 10'h001;
      repeat (4) @(posedge clk_sys);
      chk("oc cur", overCurrent, i != 4);
      shunt <= 10'h000;
      repeat (4) @(posedge clk_sys);
      chk("oc off", overCurrent, 0);
    end
    // demand 256: top bits give a quarter of the full max threshold
    apb(1, `BCLD_DEMAND_OFS, 32'h100);
    shunt <= 10'h100;
    repeat (4) @(posedge clk_sys);
    chk("oc quarter", overCurrent, 1);
    shunt <= 10'h0FF;
    repeat (4) @(posedge clk_sys);
    chk("oc below quarter", overCurrent, 0);
    // speed mode: max threshold times scale
    apb(1, `BCLD_CTRL_OFS, 32'h0);
    apb(1, `BCLD_LIMIT_OFS, 32'h03);
    shunt <= 10'h3FF;
    repeat (4) @(posedge clk_sys);
    chk("oc low scale", overCurrent, 1);
    apb(1, `BCLD_LIMIT_OFS, 32'hF3);
    shunt <= 10'h020;
    repeat (4) @(posedge clk_sys);
    chk("oc full scale", overCurrent, 0);
    // quarter max threshold at half scale gives a limit of 0x80
    apb(1, `BCLD_LIMIT_OFS, 32'h71);
    shunt <= 10'h081;
    repeat (4) @(posedge clk_sys);
    chk("oc half thr", overCurrent, 1);
    shunt <= 10'h080;
    repeat (4) @(posedge clk_sys);
    chk("oc at thr", overCurrent, 0);
    apb(1, `BCLD_LIMIT_OFS, 32'hF3);
    $display("done limit");
    // average current readback settles on the shunt level
    apb(1, `BCLD_CTRL_OFS, 32'h20);
    shunt <= 10'h100;
    repeat (300) @(posedge clk_sys);
    apb(0, `BCLD_RDBK_OFS, 0);
    chk("avg rb", rdv >= 32'hFE && rdv <= 32'h100, 1);
    apb(0, `BCLD_CURR_OFS, 0);
    chk("avg", rdv >= 32'hFE && rdv <= 32'h100, 1);
    apb(1, `BCLD_CTRL_OFS, 32'h50);
    apb(0, `BCLD_RDBK_OFS, 0);
    chk("rb demand", rdv, 32'h100);
    $display("done average");
    // fault output loops to the pull-down pin, then releases
    useDiag <= 1'b1;
    faultCond <= 1'b1;
    repeat (20) @(posedge clk_sys);
    chk("pd on", {linPulldownEn, linLine}, 2'b10);
    apb(0, `BCLD_STAT_OFS, 0);
    chk("status", rdv, 32'h4);
    // pin released: the pull-up keeps the pull-down off
    useDiag <= 1'b0;
    repeat (20) @(posedge clk_sys);
    chk("pd released", linPulldownEn, 0);
    faultCond <= 1'b0;
    repeat (2) @(posedge clk_sys);
    useDiag <= 1'b1;
    repeat (20) @(posedge clk_sys);
    chk("pd off", linPulldownEn, 0);
    apb(1, `BCLD_IRQMSK_OFS, 0);
    repeat (3) @(posedge clk_sys);
    chk("irq masked", irq, 0);
    apb(1, `BCLD_IRQMSK_OFS, 3);
    repeat (3) @(posedge clk_sys);
    chk("irq unmasked", irq, 1);
    apb(0, `BCLD_IRQST_OFS, 0);
    chk("irq pd", rdv[1], 1);
    apb(1, `BCLD_IRQST_OFS, 3);
    repeat (3) @(posedge clk_sys);
    chk("irq clear", irq, 0);
    $display("done pull-down");
    wrap_up;
  end
endmodule
`default_nettype wire
